// >>> src/fwsr_pkg.sv
// Constants for the flash write-status host controller.
// Assumes a 250 MHz clock and a parallel flash with open-drain busy pin.
package fwsr_pkg;

    // -------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_READ_NS = 70;
    localparam int T_WRITE_PULSE_NS = 35;
    localparam int T_WRITE_HIGH_NS = 30;
    localparam int T_OE_HOLD_NS = 10;
    localparam int SYNC_STAGES = 2;

    // Least times round up to whole cycles, never below one.
    function automatic int fwsr_cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Reads hold the strobe long enough for the synchroniser to catch up.
    localparam int READ_CYC = fwsr_cyc_up(T_READ_NS) + SYNC_STAGES;
    localparam int WP_CYC = fwsr_cyc_up(T_WRITE_PULSE_NS);
    localparam int WPH_CYC = fwsr_cyc_up(T_WRITE_HIGH_NS);
    localparam int OEH_CYC = fwsr_cyc_up(T_OE_HOLD_NS);
    localparam int CNT_W = 5;

    // -------------------------------------------------------------------
    // Register map of the command port
    // -------------------------------------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_RDATA = 8'h10;

    // Operation codes written to the command register.
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_POLL = 3'h2;
    localparam logic [2:0] OP_ADD_SECTOR = 3'h3;
    localparam logic [2:0] OP_READ = 3'h4;

    // Status register fields.
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_REJECT = 3;
    localparam int ST_MAYBE = 4;
    localparam int ST_READY = 5;
    localparam int ST_TIMER = 6;

    // -------------------------------------------------------------------
    // Flash status bit positions and commands
    // -------------------------------------------------------------------
    localparam int DATA_POLL_BIT = 7;
    localparam int TOGGLE_BIT_PRIMARY = 6;
    localparam int TIMING_LIMIT_FAIL_BIT = 5;
    localparam int ERASE_WINDOW_TIMER_BIT = 3;
    localparam int TOGGLE_BIT_SECTOR = 2;
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;

    // -------------------------------------------------------------------
    // Controller states
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_LAUNCH = 4'b0010,
        S_STROBE = 4'b0100,
        S_RECOV  = 4'b1000
    } fwsr_state_t;

endpackage : fwsr_pkg

// >>> src/fwsr_host.sv
// Host controller that runs flash bus cycles and interprets write status.
// Assumes the flash data pins and busy pin are asynchronous to i_clock.
//
// Contract
// RULE_01: The flash sets its timing-limit failure bit when a run exceeds its pulse limit.
// RULE_02: Programming a one over a zero halts the flash and later sets the failure bit.
// RULE_03: Programming never turns a zero into a one; only erase does.
// RULE_04: After a timing-limit failure the host writes the reset command.
// RULE_05: Only sector erase runs the erase time-out, chip erase does not.
// RULE_06: Each added sector erase command restarts the whole time-out.
// RULE_07: The erase timer bit reads zero during the time-out and one after.
// RULE_08: The host may skip the timer bit only if added commands come under 50 us apart.
// RULE_09: The host confirms acceptance by toggle status before sampling the timer bit; OP_ADD_SECTOR samples it from one read with no toggle check.
// RULE_10: Once the timer bit is one, the flash ignores all but erase suspend.
// RULE_11: While the timer bit is zero, the flash accepts further sector erase commands.
// RULE_12: The host checks the timer bit before and after each added sector command.
// RULE_13: The host presents a valid address when reading polling or sector toggle status.
// RULE_14: The primary toggle bit changes on every status read during an embedded run.
// RULE_15: The busy pin is low while programming or erasing and high when ready.
// RULE_16: Program status shows inverted bit seven, toggling, no failure and busy low.
// RULE_17: Erase and erase-suspend reads show the documented polling and toggle patterns.
//
// Our own choices: the plain strobed port and the placing of the registers.
module fwsr_host
    import fwsr_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Command port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Flash bus
    output logic [ADDR_W-1:0] o_flash_addr,
    input wire logic [DATA_W-1:0] i_flash_dq,
    output logic [DATA_W-1:0] o_flash_dq,
    output logic o_flash_dq_oe,
    output logic o_flash_ce_n,
    output logic o_flash_oe_n,
    output logic o_flash_we_n,
    output logic o_flash_reset_n,
    input wire logic i_flash_ready_busy
);

    // -------------------------------------------------------------------
    // Parameter checks
    // -------------------------------------------------------------------
    if (DATA_W < 8 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 32) begin : g_bad_param
        $error("fwsr_host: DATA_W must be 8..32 and ADDR_W 1..32");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        fwsr_state_t state;
        logic [2:0] op;
        logic [2:0] step;
        logic [CNT_W-1:0] cnt;
        logic cyc_wr;
        logic [1:0] reads;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] first;
        logic [DATA_W-1:0] last;
        logic busy;
        logic done;
        logic fail;
        logic reject;
        logic maybe;
        logic timer;
        logic [DATA_W-1:0] dq_s1;
        logic [DATA_W-1:0] dq_s2;
        logic ry_s1;
        logic ry_s2;
        logic [ADDR_W-1:0] fa;
        logic [DATA_W-1:0] fdo;
        logic fdo_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic [31:0] rdata;
    } fwsr_regs_t;

    fwsr_regs_t st_reg;
    fwsr_regs_t st_next;

    localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYC - 1);
    localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC - 1);
    localparam logic [CNT_W-1:0] WPH_CNT = CNT_W'(WPH_CYC - 1);
    localparam logic [CNT_W-1:0] OEH_CNT = CNT_W'(OEH_CYC - 1);

    function automatic logic [31:0] fwsr_status(input fwsr_regs_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ST_BUSY] = s.busy;
        w[ST_DONE] = s.done;
        w[ST_FAIL] = s.fail;
        w[ST_REJECT] = s.reject;
        w[ST_MAYBE] = s.maybe;
        w[ST_READY] = s.ry_s2;
        w[ST_TIMER] = s.timer;
        return w;
    endfunction

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.dq_s1 = i_flash_dq;
        st_next.dq_s2 = st_reg.dq_s1;
        st_next.ry_s1 = i_flash_ready_busy;
        st_next.ry_s2 = st_reg.ry_s1;
        st_next.rst_n = 1'b1;
        st_next.rdata = 32'h0000_0000;

        if (i_rd) begin
            if (i_addr == OFF_STATUS) begin
                st_next.rdata = fwsr_status(st_reg);
            end else if (i_addr == OFF_RDATA) begin
                st_next.rdata = 32'(st_reg.last);
            end else if (i_addr == OFF_ADDR) begin
                st_next.rdata = 32'(st_reg.addr);
            end else if (i_addr == OFF_WDATA) begin
                st_next.rdata = 32'(st_reg.wdata);
            end
        end

        // Operands are frozen while an operation runs so a cycle never sees them move.
        if (i_wr && !st_reg.busy) begin
            if (i_addr == OFF_ADDR) begin
                st_next.addr = i_wdata[ADDR_W-1:0];
            end else if (i_addr == OFF_WDATA) begin
                st_next.wdata = i_wdata[DATA_W-1:0];
            end
        end

        case (st_reg.state)
            S_IDLE: begin
                if (i_wr && i_addr == OFF_CMD && i_wdata[2:0] != OP_NONE) begin
                    st_next.op = i_wdata[2:0];
                    st_next.step = 3'h0;
                    st_next.reads = 2'h0;
                    st_next.busy = 1'b1;
                    st_next.done = 1'b0;
                    st_next.fail = 1'b0;
                    st_next.reject = 1'b0;
                    st_next.maybe = 1'b0;
                    st_next.state = S_LAUNCH;
                end
            end
            S_LAUNCH: begin
                // Default is a status read at the software-given address. [RULE_13]
                st_next.state = S_STROBE;
                st_next.cyc_wr = 1'b0;
                st_next.fa = st_reg.addr;
                st_next.cnt = READ_CNT;
                case (st_reg.op)
                    OP_WRITE: begin
                        if (st_reg.step != 3'h0) begin
                            st_next.state = S_IDLE;
                        end else begin
                            st_next.cyc_wr = 1'b1;
                            st_next.fdo = st_reg.wdata;
                        end
                    end
                    OP_READ: begin
                        if (st_reg.step != 3'h0) begin
                            st_next.state = S_IDLE;
                        end
                    end
                    OP_POLL: begin
                        // Two reads before any verdict; the pair is sliding. [RULE_09] [RULE_14]
                        if (st_reg.step == 3'h2) begin
                            st_next.state = S_LAUNCH;
                            if (st_reg.first[TOGGLE_BIT_PRIMARY] ==
                                st_reg.last[TOGGLE_BIT_PRIMARY]) begin
                                st_next.state = S_IDLE;
                            end else if (st_reg.last[TIMING_LIMIT_FAIL_BIT]) begin
                                st_next.step = 3'h3; // [RULE_01]
                            end else begin
                                st_next.step = 3'h1;
                            end
                        end else if (st_reg.step == 3'h4) begin
                            st_next.state = S_LAUNCH;
                            st_next.step = 3'h5;
                            if (st_reg.first[TOGGLE_BIT_PRIMARY] ==
                                st_reg.last[TOGGLE_BIT_PRIMARY]) begin
                                st_next.state = S_IDLE;
                            end
                        end else if (st_reg.step == 3'h5) begin
                            // Still toggling with the limit bit set: send the reset command. [RULE_04]
                            st_next.cyc_wr = 1'b1;
                            st_next.fdo = DATA_W'(CMD_RESET);
                        end else if (st_reg.step == 3'h6) begin
                            st_next.fail = 1'b1;
                            st_next.state = S_IDLE;
                        end
                    end
                    OP_ADD_SECTOR: begin
                        // The timer bit is read on both sides of the added command. [RULE_12] [RULE_08]
                        if (st_reg.step == 3'h1) begin
                            st_next.state = S_LAUNCH;
                            st_next.step = 3'h2;
                            st_next.timer = st_reg.last[ERASE_WINDOW_TIMER_BIT]; // [RULE_07]
                            if (st_reg.last[ERASE_WINDOW_TIMER_BIT]) begin
                                st_next.reject = 1'b1; // [RULE_10]
                                st_next.state = S_IDLE;
                            end
                        end else if (st_reg.step == 3'h2) begin
                            st_next.cyc_wr = 1'b1; // [RULE_11]
                            st_next.fdo = DATA_W'(CMD_SECTOR_ERASE);
                        end else if (st_reg.step == 3'h4) begin
                            st_next.timer = st_reg.last[ERASE_WINDOW_TIMER_BIT];
                            st_next.maybe = st_reg.last[ERASE_WINDOW_TIMER_BIT]; // [RULE_12]
                            st_next.state = S_IDLE;
                        end
                    end
                    default: begin
                        st_next.state = S_IDLE;
                    end
                endcase
                if (st_next.state == S_IDLE) begin
                    st_next.busy = 1'b0;
                    st_next.done = 1'b1;
                end else if (st_next.state == S_STROBE) begin
                    st_next.ce_n = 1'b0;
                    st_next.oe_n = st_next.cyc_wr;
                    st_next.we_n = !st_next.cyc_wr;
                    st_next.fdo_oe = st_next.cyc_wr;
                    if (st_next.cyc_wr) begin
                        st_next.cnt = WP_CNT;
                    end
                end
            end
            S_STROBE: begin
                st_next.cnt = st_reg.cnt - 1'b1;
                if (st_reg.cnt == '0) begin
                    if (!st_reg.cyc_wr) begin
                        st_next.first = st_reg.last;
                        st_next.last = st_reg.dq_s2;
                        st_next.reads = (st_reg.reads == 2'h3) ? 2'h3 : st_reg.reads + 2'h1;
                    end
                    st_next.ce_n = 1'b1;
                    st_next.oe_n = 1'b1;
                    st_next.we_n = 1'b1;
                    st_next.cnt = st_reg.cyc_wr ? WPH_CNT : OEH_CNT;
                    st_next.state = S_RECOV;
                end
            end
            S_RECOV: begin
                st_next.cnt = st_reg.cnt - 1'b1;
                if (st_reg.cnt == '0) begin
                    st_next.fdo_oe = 1'b0;
                    st_next.step = st_reg.step + 3'h1;
                    st_next.state = S_LAUNCH;
                end
            end
            default: begin
                st_next.state = S_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_reg <= '0;
            st_reg.state <= S_IDLE;
            st_reg.ce_n <= 1'b1;
            st_reg.oe_n <= 1'b1;
            st_reg.we_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_flash_addr = st_reg.fa;
    assign o_flash_dq = st_reg.fdo;
    assign o_flash_dq_oe = st_reg.fdo_oe;
    assign o_flash_ce_n = st_reg.ce_n;
    assign o_flash_oe_n = st_reg.oe_n;
    assign o_flash_we_n = st_reg.we_n;
    assign o_flash_reset_n = st_reg.rst_n;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence se_write_end;
        $rose(o_flash_we_n) && st_reg.op == OP_ADD_SECTOR;
    endsequence

    sequence status_read_start;
        $fell(o_flash_oe_n);
    endsequence

    reset_after_fail_a: assert property ($rose(st_reg.fail) |-> // [RULE_04]
        o_flash_dq == DATA_W'(CMD_RESET) && st_reg.op == OP_POLL)
        else $error("failure reported without a reset command");
    check_before_add_a: assert property ( // [RULE_12]
        ($fell(o_flash_we_n) && st_reg.op == OP_ADD_SECTOR) |->
        !st_reg.timer && st_reg.reads == 2'h1 && o_flash_dq == DATA_W'(CMD_SECTOR_ERASE))
        else $error("sector command sent without a prior timer check");
    check_after_add_a: assert property (se_write_end |-> ##[1:20] status_read_start) // [RULE_12]
        else $error("no timer check after an added sector command");
    status_addr_a: assert property (!o_flash_oe_n |-> o_flash_addr == st_reg.addr) // [RULE_13]
        else $error("status read at an address other than the given one");
    poll_twice_a: assert property ( // [RULE_09]
        ($rose(st_reg.done) && st_reg.op == OP_POLL) |-> st_reg.reads >= 2'h2)
        else $error("poll verdict from fewer than two reads");
    maybe_flag_a: assert property ($rose(st_reg.maybe) |-> st_reg.timer) // [RULE_12]
        else $error("maybe-rejected flag without timer bit high");

endmodule : fwsr_host

// >>> verif/fwsr_flash_model.sv
// Behavioural parallel flash that answers host bus cycles with write status.
// Assumes output enable falls only for reads and write enable only for writes.
module fwsr_flash_model
    import fwsr_pkg::*;
#(
    parameter int TO_READS = 3,
    parameter int P_READS = 4,
    parameter int ER_READS = 4
) (
    // Flash bus
    input wire logic [17:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    output logic [15:0] o_dq,
    output logic o_ready_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Status state, advanced per read cycle rather than per time
    // ---------------------------------------------------------------
    localparam logic [15:0] CHIP_ERASE = 16'h0010;
    logic [15:0] mem [16];
    logic [15:0] wd = CMD_RESET;
    logic [15:0] last = 16'h0000;
    logic [15:0] cur;
    logic busy = 1'b0;
    logic erasing = 1'b0;
    logic fail_mode = 1'b0;
    logic tog = 1'b0;
    logic pd7 = 1'b0;
    int left = 0;
    int to_cnt = 0;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
    end
    always_comb begin
        if (!busy) cur = mem[i_addr[3:0]];
        else if (erasing) cur = {9'h000, tog, 2'b00, to_cnt >= TO_READS, tog, 2'b00};
        else cur = {8'h00, ~pd7, tog, fail_mode && left == 0, 5'h00};
    end
    // A released bus shows the inverse of the last word so stale data never passes.
    assign o_dq = (!i_ce_n && !i_oe_n) ? cur : ~last;
    assign o_ready_busy = !busy;
    always @(posedge i_oe_n) begin
        last = cur;
        if (busy) begin
            tog = !tog;
            if (erasing && to_cnt < TO_READS) to_cnt++;
            else if (left > 0) left--;
            if (left == 0 && !fail_mode) busy = 1'b0;
        end
    end
    always @(negedge i_we_n) begin
        #1 wd = i_dq;
    end
    // Commands other than reset and early added sectors are ignored while busy.
    always @(posedge i_we_n) begin
        if (wd == CMD_RESET) begin
            busy = 1'b0;
            fail_mode = 1'b0;
        end else if (busy && erasing && to_cnt < TO_READS && wd == CMD_SECTOR_ERASE) begin
            to_cnt = 0;
        end else if (!busy && (wd == CMD_SECTOR_ERASE || wd == CHIP_ERASE)) begin
            busy = 1'b1;
            erasing = 1'b1;
            to_cnt = (wd == CHIP_ERASE) ? TO_READS : 0;
            left = ER_READS;
        end else if (!busy) begin
            pd7 = wd[7];
            fail_mode = |(wd & ~mem[i_addr[3:0]]);
            if (!fail_mode) mem[i_addr[3:0]] = mem[i_addr[3:0]] & wd;
            busy = 1'b1;
            erasing = 1'b0;
            left = P_READS;
        end
    end
endmodule // fwsr_flash_model

// >>> verif/tb.sv
// Self-checking bench for the flash write-status host controller.
// Assumes the behavioural flash model on the far side of the flash bus.
module tb
    import fwsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Harness
    // ---------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [31:0] o_rdata;
    logic [17:0] f_addr;
    logic [15:0] h_dq, m_dq, f_dq;
    logic dq_oe, ce_n, oe_n, we_n, reset_n, ready;
    int fails = 0;
    int tests_run = 0;
    assign f_dq = dq_oe ? h_dq : m_dq;
    fwsr_host dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_addr(f_addr), .i_flash_dq(f_dq),
        .o_flash_dq(h_dq), .o_flash_dq_oe(dq_oe), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
        .o_flash_we_n(we_n), .o_flash_reset_n(reset_n), .i_flash_ready_busy(ready));
    fwsr_flash_model flash_u (.i_addr(f_addr), .i_dq(f_dq), .i_ce_n(ce_n), .i_oe_n(oe_n),
        .i_we_n(we_n), .o_dq(m_dq), .o_ready_busy(ready));
    initial begin
        forever #2 i_clock = ~i_clock;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Runs one operation and waits, bounded, until the busy flag drops.
    task automatic run(input logic [2:0] op, output logic [31:0] st);
        wr(OFF_CMD, {29'h0, op});
        for (int n = 0; n < 4000; n++) begin
            rd(OFF_STATUS, st);
            if (st[ST_BUSY] === 1'b0) return;
        end
        chk("operation wait", 32'h1, 32'h0);
        finish_test();
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] st;
        chk("reset pin in reset", {31'h0, reset_n}, 32'h0);
        chk("strobes in reset", {29'h0, ce_n, oe_n, we_n}, 32'h7);
        chk("drive in reset", {31'h0, dq_oe}, 32'h0);
        i_rst <= 1'b0;
        // The ready pin only shows in status once it has crossed the two sync flops.
        repeat (2) @(posedge i_clock);
        rd(OFF_STATUS, st);
        chk("status after reset", st, 32'h0000_0020);
        rd(8'h40, st);
        chk("unmapped read", st, 32'h0);
        chk("reset pin after", {31'h0, reset_n}, 32'h1);
    endtask
    task automatic t_program();
        logic [31:0] st, r1, r2;
        wr(OFF_ADDR, 32'h0000_0003);
        wr(OFF_WDATA, 32'h0000_00FF);
        run(OP_WRITE, st);
        chk("ready pin busy", {31'h0, st[ST_READY]}, 32'h0);
        run(OP_READ, st);
        rd(OFF_RDATA, r1);
        run(OP_READ, st);
        rd(OFF_RDATA, r2);
        chk("poll bit", {31'h0, r1[DATA_POLL_BIT]}, 32'h0);
        chk("toggle", {31'h0, r1[TOGGLE_BIT_PRIMARY] ^ r2[TOGGLE_BIT_PRIMARY]}, 32'h1);
        chk("fail bit", {31'h0, r1[TIMING_LIMIT_FAIL_BIT]}, 32'h0);
        run(OP_POLL, st);
        chk("program status", st & 32'h0000_003F, 32'h0000_0022);
    endtask
    task automatic t_fail();
        logic [31:0] st, r1;
        wr(OFF_WDATA, 32'h0000_FF00);
        run(OP_WRITE, st);
        run(OP_POLL, st);
        chk("fail status", st & 32'h0000_0007, 32'h0000_0006);
        run(OP_READ, st);
        chk("ready after reset", st & 32'h0000_0027, 32'h0000_0022);
        rd(OFF_RDATA, r1);
        chk("array after fail", r1, 32'h0000_00FF);
    endtask
    task automatic t_erase();
        logic [31:0] st, r1;
        wr(OFF_WDATA, {16'h0, CMD_SECTOR_ERASE});
        run(OP_WRITE, st);
        run(OP_ADD_SECTOR, st);
        chk("early add", st & 32'h0000_005E, 32'h0000_0002);
        run(OP_READ, st);
        run(OP_READ, st);
        rd(OFF_RDATA, r1);
        chk("timer restart", {31'h0, r1[ERASE_WINDOW_TIMER_BIT]}, 32'h0);
        run(OP_ADD_SECTOR, st);
        chk("late add", st & 32'h0000_001E, 32'h0000_000A);
        run(OP_READ, st);
        rd(OFF_RDATA, r1);
        chk("erase word", r1 & 32'h0000_00A8, 32'h0000_0008);
        run(OP_POLL, st);
        chk("erase done", st & 32'h0000_0027, 32'h0000_0022);
        wr(OFF_WDATA, 32'h0000_0010);
        run(OP_WRITE, st);
        run(OP_READ, st);
        rd(OFF_RDATA, r1);
        chk("chip erase timer", {31'h0, r1[ERASE_WINDOW_TIMER_BIT]}, 32'h1);
        run(OP_POLL, st);
        chk("chip erase done", st & 32'h0000_0007, 32'h0000_0002);
        // The window closes between the two checks, so the added command is not taken.
        wr(OFF_WDATA, {16'h0, CMD_SECTOR_ERASE});
        run(OP_WRITE, st);
        run(OP_READ, st);
        run(OP_READ, st);
        run(OP_ADD_SECTOR, st);
        chk("maybe not taken", st & 32'h0000_005E, 32'h0000_0052);
        run(OP_POLL, st);
        chk("erase after maybe", st & 32'h0000_0027, 32'h0000_0022);
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        t_reset();
        t_program();
        t_fail();
        t_erase();
        finish_test();
    end
endmodule // tb
